/* testbench.sv */
/* self-checking bench of the filter setup block; assumes the checker and the thread model. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tfsa_pkg::*;
  logic clock = 0, arst_n = 0, reqValid = 0, oneBitTexelFormat = 0, stall = 0;
  logic reqReady, smpValid, smpReady, smpLast, unsupportedCombo, blkValid, blkReady, resValid;
  logic [COORD_W-1:0] coordAxisU = 16'h0800, coordAxisV = 16'h0800, coordAxisR = 16'h0800;
  logic [COORD_W-1:0] coordHomogeneousRecip = 16'h1000, majorStepU = 16'h1000, majorStepV = 0;
  logic [DL_W-1:0] detailLevel = 0;
  tfsa_surf_e surfType = SURF_2D;
  logic [2:0] cubeFace = 3'h0, maxFootprintRatio = 3'h7, smpFace;
  logic [LEN_W-1:0] majorLen = 12'h030, minorLen = 12'h010, detailAxisLen;
  tfsa_filt_e shrinkFilterSelect = FILTER_CLOSEST_TEXEL, enlargeFilterSelect = FILTER_CLOSEST_TEXEL;
  tfsa_addr_e addrModeU = ADDR_REPEAT, addrModeV = ADDR_REPEAT, addrModeR = ADDR_REPEAT;
  logic [SZ_W-1:0] sizeLog2U = 4'h4, sizeLog2V = 4'h4, sizeLog2R = 4'h4;
  logic [KN_W-1:0] kernelWidth = 3'h2, kernelHeight = 3'h2;
  logic [AIDX_W-1:0] smpU, smpV, smpR, qU[$], qV[$], qR[$];
  logic [WT_W-1:0] smpTexelWeight, smpGroupWeight, footprintRatio, qW[$], qG[$];
  logic [BLK_BITS-1:0] blkTexels, pattern = 64'h1;
  logic [INT_W-1:0] resRed, resGreen, resBlue, resAlpha;
  logic gotLast, sawCombo;
  int num_errors = 0, n_tests = 0, cycles = 0, k;
  tfsa_surf_e surfList[4] = '{SURF_1D, SURF_2D, SURF_3D, SURF_CUBE};
  int surfCount[4] = '{2, 4, 8, 4};
  always #5 clock = ~clock;
  tfsa_filter_setup u_dut (.clock, .arst_n, .reqValid, .reqReady, .coordAxisU, .coordAxisV,
    .coordAxisR, .coordHomogeneousRecip, .detailLevel, .surfType, .oneBitTexelFormat, .cubeFace,
    .majorLen, .minorLen, .majorStepU, .majorStepV, .shrinkFilterSelect, .enlargeFilterSelect,
    .maxFootprintRatio, .addrModeU, .addrModeV, .addrModeR, .sizeLog2U, .sizeLog2V, .sizeLog2R,
    .kernelWidth, .kernelHeight, .smpValid, .smpReady, .smpU, .smpV, .smpR, .smpFace,
    .smpTexelWeight, .smpGroupWeight, .smpLast, .footprintRatio, .detailAxisLen,
    .unsupportedCombo, .blkValid, .blkReady, .blkTexels, .resValid, .resRed, .resGreen,
    .resBlue, .resAlpha);
  tfsa_eu_model u_model (.clock, .arst_n, .stall, .pattern, .smpReady, .blkReady, .blkValid,
    .blkTexels);
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after a falling edge; returns once the block is idle again
  task automatic run(input tfsa_filt_e shr, input tfsa_filt_e enl, input tfsa_surf_e s);
    qU.delete();
    qV.delete();
    qR.delete();
    qW.delete();
    qG.delete();
    gotLast = 1'b0;
    sawCombo = 1'b0;
    shrinkFilterSelect = shr;
    enlargeFilterSelect = enl;
    surfType = s;
    reqValid = 1'b1;
    @(posedge clock);
    @(negedge clock);
    reqValid = 1'b0;
    for (k = 0; k < 300 && !(gotLast && reqReady); k++) begin
      @(negedge clock);
    end
    check(gotLast, 1'b1);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (smpValid && smpReady) begin
      qU.push_back(smpU);
      qV.push_back(smpV);
      qR.push_back(smpR);
      qW.push_back(smpTexelWeight);
      qG.push_back(smpGroupWeight);
      gotLast = gotLast | smpLast;
    end
    if (unsupportedCombo) begin
      sawCombo = 1'b1;
    end
    if (cycles == 6000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    run(FILTER_INTERPOLATED, FILTER_CLOSEST_TEXEL, SURF_2D);
    check({16'(qU.size()), qU[0], qV[0], qW[0]}, {16'h1, 15'h8, 15'h8, WT_ONE});
    detailLevel = 11'h040;
    run(FILTER_INTERPOLATED, FILTER_CLOSEST_TEXEL, SURF_2D);
    check(qU.size(), 4);
    check({qU[0], qV[0], qU[1], qV[1]}, {15'h7, 15'h7, 15'h8, 15'h7});
    check({qU[2], qV[2], qU[3], qV[3]}, {15'h7, 15'h8, 15'h8, 15'h8});
    check({qW[0], qW[1], qW[2], qW[3]}, {4{9'h040}});
    detailLevel = 11'h7c0;
    run(FILTER_INTERPOLATED, FILTER_CLOSEST_TEXEL, SURF_2D);
    check(qU.size(), 1);
    detailLevel = 11'h040;
    stall = 1'b1;
    for (int i = 0; i < 4; i++) begin
      run(FILTER_INTERPOLATED, FILTER_INTERPOLATED, surfList[i]);
      check(qU.size(), surfCount[i]);
    end
    stall = 1'b0;
    run(FILTER_INTERPOLATED, FILTER_INTERPOLATED, SURF_BUFFER);
    check({sawCombo, qU.size()}, {1'b1, 32'h1});
    {coordAxisU, coordAxisV, coordAxisR} = {3{16'h1800}};
    addrModeV = ADDR_REFLECT;
    addrModeR = ADDR_EDGE_HOLD;
    run(FILTER_CLOSEST_TEXEL, FILTER_CLOSEST_TEXEL, SURF_3D);
    check({qU[0], qV[0], qR[0]}, {15'h8, 15'h7, 15'hf});
    {coordAxisU, coordAxisV} = {2{16'hf800}};
    addrModeU = ADDR_REFLECT_THEN_HOLD;
    addrModeV = ADDR_EDGE_HOLD;
    addrModeR = ADDR_REFLECT_THEN_HOLD;
    run(FILTER_CLOSEST_TEXEL, FILTER_CLOSEST_TEXEL, SURF_3D);
    check({qU[0], qV[0], qR[0]}, {15'h7, 15'h0, 15'hf});
    addrModeU = ADDR_FACE_CROSSING;
    run(FILTER_CLOSEST_TEXEL, FILTER_CLOSEST_TEXEL, SURF_CUBE);
    check({smpFace, qU[0]}, {CUBE_NEXT[0], 15'h8});
    {coordAxisU, coordAxisV, coordAxisR} = {3{16'h0800}};
    addrModeU = ADDR_REPEAT;
    addrModeV = ADDR_REPEAT;
    addrModeR = ADDR_REPEAT;
    run(FILTER_ELONGATED_FOOTPRINT, FILTER_CLOSEST_TEXEL, SURF_2D);
    check({footprintRatio, detailAxisLen, qU.size()}, {9'h030, 12'h010, 32'h10});
    check({qG[0], qG[4], qG[8], qG[15]}, {9'h008, 9'h010, 9'h010, 9'h008});
    check(qU[4] - qU[0], 15'h1);
    run(FILTER_ELONGATED_FOOTPRINT, FILTER_CLOSEST_TEXEL, SURF_3D);
    check({sawCombo, qU.size()}, {1'b1, 32'h8});
    maxFootprintRatio = 3'h0;
    majorLen = 12'h100;
    run(FILTER_ELONGATED_FOOTPRINT, FILTER_CLOSEST_TEXEL, SURF_2D);
    check({footprintRatio, qU.size()}, {9'h020, 32'h10});
    maxFootprintRatio = 3'h7;
    majorLen = 12'hff0;
    run(FILTER_ELONGATED_FOOTPRINT, FILTER_CLOSEST_TEXEL, SURF_2D);
    check({footprintRatio, qU.size()}, {9'h100, 32'h48});
    oneBitTexelFormat = 1'b1;
    run(FILTER_ONE_BIT_KERNEL, FILTER_CLOSEST_TEXEL, SURF_2D);
    check({qU[0], qV[0]}, {15'h7, 15'h7});
    check({resRed, resGreen, resBlue, resAlpha}, {4{8'h3f}});
    {kernelWidth, kernelHeight} = {3'h7, 3'h3};
    pattern = '1;
    run(FILTER_ONE_BIT_KERNEL, FILTER_CLOSEST_TEXEL, SURF_2D);
    check({resRed, resAlpha}, {2{8'hff}});
    oneBitTexelFormat = 1'b0;
    run(FILTER_ONE_BIT_KERNEL, FILTER_CLOSEST_TEXEL, SURF_2D);
    check({sawCombo, qU.size()}, {1'b1, 32'h1});
    summarize();
  end
endmodule
`default_nettype wire

/* tfsa_axis_addr.sv */
/*
  out-of-range addressing of one integer texel index on one axis.
  assumes the map size on the axis is 2**sizeLog2 texels.
*/
`timescale 1ns/100ps
`default_nettype none
module tfsa_axis_addr (
  // texel index before addressing
  input wire logic [tfsa_pkg::IDX_W-1:0] idx,
  input wire logic [tfsa_pkg::SZ_W-1:0] sizeLog2,
  input wire tfsa_pkg::tfsa_addr_e mode,
  // addressed index and face crossing
  output logic [tfsa_pkg::AIDX_W-1:0] addrIdx,
  output logic crossLo,
  output logic crossHi
);
  import tfsa_pkg::*;
  logic [IDX_W-1:0] size, mask, low, mirOnce;
  logic neg, over;
  assign size = IDX_W'(1) << sizeLog2;
  assign mask = size - IDX_W'(1);
  assign low = idx & mask;
  assign neg = idx[IDX_W-1];
  assign over = !neg && (idx > mask);
  assign mirOnce = neg ? ~idx : idx;
  always_comb begin
    crossLo = 1'b0;
    crossHi = 1'b0;
    case (mode)
      ADDR_REPEAT: addrIdx = low[AIDX_W-1:0];
      ADDR_REFLECT: begin
        // odd intervals run backwards; two's complement keeps -1 mapping to 0
        addrIdx = (|(idx & size)) ? AIDX_W'(mask - low) : low[AIDX_W-1:0];
      end
      ADDR_REFLECT_THEN_HOLD: begin
        addrIdx = (mirOnce > mask) ? mask[AIDX_W-1:0] : mirOnce[AIDX_W-1:0];
      end
      ADDR_FACE_CROSSING: begin
        crossLo = neg;
        crossHi = over;
        addrIdx = low[AIDX_W-1:0];
      end
      default: begin
        // edge hold also keeps cube samples on the hit face
        addrIdx = neg ? '0 : (over ? mask[AIDX_W-1:0] : idx[AIDX_W-1:0]);
      end
    endcase
  end
endmodule
`default_nettype wire

/* tfsa_eu_model.sv */
/* sample sink and one-bit block source; assumes blkReady is high only while a block is owed. */
`timescale 1ns/100ps
`default_nettype none
module tfsa_eu_model (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // bench controls
  input wire logic stall,
  input wire logic [tfsa_pkg::BLK_BITS-1:0] pattern,
  // design side
  output logic smpReady,
  input wire logic blkReady,
  output logic blkValid,
  output logic [tfsa_pkg::BLK_BITS-1:0] blkTexels
);
  import tfsa_pkg::*;
  logic phase_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 1'b0;
      blkValid <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
      // one idle cycle before offering, held until taken
      if (blkValid && blkReady) begin
        blkValid <= 1'b0;
      end else if (blkReady) begin
        blkValid <= 1'b1;
      end
    end
  end
  assign smpReady = !stall || phase_r;
  // no stale data while not offered
  assign blkTexels = blkValid ? pattern : ~pattern;
endmodule
`default_nettype wire

/* tfsa_filter_setup.sv */
/*
  within-level filter choice, footprint, sample positions, weights and per-axis addressing.
  assumes detail level, footprint axes and fetched mono blocks come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tfsa_filter_setup (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // sample request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [tfsa_pkg::COORD_W-1:0] coordAxisU,
  input wire logic [tfsa_pkg::COORD_W-1:0] coordAxisV,
  input wire logic [tfsa_pkg::COORD_W-1:0] coordAxisR,
  input wire logic [tfsa_pkg::COORD_W-1:0] coordHomogeneousRecip,
  input wire logic [tfsa_pkg::DL_W-1:0] detailLevel,
  input wire tfsa_pkg::tfsa_surf_e surfType,
  input wire logic oneBitTexelFormat,
  input wire logic [2:0] cubeFace,
  // footprint of the pixel projection
  input wire logic [tfsa_pkg::LEN_W-1:0] majorLen,
  input wire logic [tfsa_pkg::LEN_W-1:0] minorLen,
  input wire logic [tfsa_pkg::COORD_W-1:0] majorStepU,
  input wire logic [tfsa_pkg::COORD_W-1:0] majorStepV,
  // sampler state
  input wire tfsa_pkg::tfsa_filt_e shrinkFilterSelect,
  input wire tfsa_pkg::tfsa_filt_e enlargeFilterSelect,
  input wire logic [2:0] maxFootprintRatio,
  input wire tfsa_pkg::tfsa_addr_e addrModeU,
  input wire tfsa_pkg::tfsa_addr_e addrModeV,
  input wire tfsa_pkg::tfsa_addr_e addrModeR,
  input wire logic [tfsa_pkg::SZ_W-1:0] sizeLog2U,
  input wire logic [tfsa_pkg::SZ_W-1:0] sizeLog2V,
  input wire logic [tfsa_pkg::SZ_W-1:0] sizeLog2R,
  input wire logic [tfsa_pkg::KN_W-1:0] kernelWidth,
  input wire logic [tfsa_pkg::KN_W-1:0] kernelHeight,
  // addressed texel samples
  output logic smpValid,
  input wire logic smpReady,
  output logic [tfsa_pkg::AIDX_W-1:0] smpU,
  output logic [tfsa_pkg::AIDX_W-1:0] smpV,
  output logic [tfsa_pkg::AIDX_W-1:0] smpR,
  output logic [2:0] smpFace,
  output logic [tfsa_pkg::WT_W-1:0] smpTexelWeight,
  output logic [tfsa_pkg::RATIO_W-1:0] smpGroupWeight,
  output logic smpLast,
  // per-request setup results
  output logic [tfsa_pkg::RATIO_W-1:0] footprintRatio,
  output logic [tfsa_pkg::LEN_W-1:0] detailAxisLen,
  output logic unsupportedCombo,
  // one-bit block and result
  input wire logic blkValid,
  output logic blkReady,
  input wire logic [tfsa_pkg::BLK_BITS-1:0] blkTexels,
  output logic resValid,
  output logic [tfsa_pkg::INT_W-1:0] resRed,
  output logic [tfsa_pkg::INT_W-1:0] resGreen,
  output logic [tfsa_pkg::INT_W-1:0] resBlue,
  output logic [tfsa_pkg::INT_W-1:0] resAlpha
);
  import tfsa_pkg::*;

  typedef struct packed {
    tfsa_state_e st;
    tfsa_filt_e filt;
    tfsa_surf_e surf;
    logic [2:0] face;
    logic [AXES-1:0][2:0] mode;
    logic [AXES-1:0][SZ_W-1:0] sz;
    logic [AXES-1:0][POS_W-1:0] cur;
    logic [1:0][POS_W-1:0] step;
    logic [4:0] k;
    logic [4:0] ways;
    logic [2:0] t;
    logic [1:0] nDim;
    logic [RATIO_W-1:0] ratio;
    logic [RATIO_W-1:0] endW;
    logic [KN_W-1:0] nu;
    logic [KN_W-1:0] nv;
    logic [LEN_W-1:0] detAxis;
    logic bad;
    logic smpValid;
    logic [AXES-1:0][AIDX_W-1:0] smpIdx;
    logic [2:0] smpFace;
    logic [WT_W-1:0] smpTexW;
    logic [RATIO_W-1:0] smpGrpW;
    logic smpLast;
    logic resValid;
    logic [INT_W-1:0] resI;
  } tfsa_reg_s;

  tfsa_reg_s s_r, s_nxt;

  // request decode
  logic mag, fallback;
  tfsa_filt_e sel, effFilt;
  logic [1:0] reqDim;
  assign mag = $signed(detailLevel) <= $signed(DL_W'(0));
  assign sel = mag ? enlargeFilterSelect : shrinkFilterSelect;
  always_comb begin
    effFilt = sel;
    // illegal pairings degrade to a supported filter instead of hanging
    case (sel)
      FILTER_INTERPOLATED: if (surfType == SURF_BUFFER) effFilt = FILTER_CLOSEST_TEXEL;
      FILTER_ELONGATED_FOOTPRINT: begin
        if (surfType == SURF_BUFFER) effFilt = FILTER_CLOSEST_TEXEL;
        else if (surfType == SURF_3D) effFilt = FILTER_INTERPOLATED;
      end
      FILTER_ONE_BIT_KERNEL: begin
        if (surfType != SURF_2D || !oneBitTexelFormat) effFilt = FILTER_CLOSEST_TEXEL;
      end
      default: effFilt = sel;
    endcase
  end
  assign fallback = effFilt != sel;
  always_comb begin
    reqDim = 2'h0;
    if (effFilt == FILTER_ELONGATED_FOOTPRINT) reqDim = 2'h2;
    else if (effFilt == FILTER_INTERPOLATED) begin
      case (surfType)
        SURF_1D: reqDim = 2'h1;
        SURF_3D: reqDim = 2'h3;
        default: reqDim = 2'h2;
      endcase
    end
  end

  // footprint ratio and sub-sample count
  logic [15:0] ratioRaw;
  logic [RATIO_W-1:0] ratioLim, ratioCap, endW;
  logic [4:0] ways;
  assign ratioRaw = (minorLen == '0) ? '1 : 16'({majorLen, 4'h0} / minorLen);
  // five bits so the largest code reaches sixteen without wrapping
  assign ratioLim = RATIO_W'({1'b0, maxFootprintRatio, 1'b0} + 5'h02) << RFRAC_W;
  always_comb begin
    ratioCap = ratioRaw[RATIO_W-1:0];
    if (ratioRaw > 16'(ratioLim)) ratioCap = ratioLim;
    if (ratioRaw < 16'(RATIO_ONE)) ratioCap = RATIO_ONE;
  end
  assign ways = {ratioCap[RATIO_W-1:RFRAC_W+1], 1'b0} + WAYS_STEP;
  // ends share what is left once the interior sub-samples take one each
  assign endW = (ratioCap - (RATIO_W'(ways - WAYS_STEP) << RFRAC_W)) >> 1;

  // homogeneous scaling and start positions per axis
  logic [AXES-1:0][COORD_W-1:0] coordIn;
  logic [AXES-1:0][SZ_W-1:0] szIn;
  logic [1:0][POS_W-1:0] stepIn;
  logic [AXES-1:0][POS_W-1:0] startPos;
  logic [AXES-1:0][AIDX_W-1:0] aIdx;
  logic [AXES-1:0] crossLo, crossHi, tBit;
  logic [AXES-1:0][WT_W-1:0] wAx;
  assign coordIn = {coordAxisR, coordAxisV, coordAxisU};
  assign szIn = {sizeLog2R, sizeLog2V, sizeLog2U};
  assign stepIn[0] = POS_W'($signed(majorStepU));
  assign stepIn[1] = POS_W'($signed(majorStepV));
  assign tBit = s_r.t;

  genvar ax;
  generate
    for (ax = 0; ax < AXES; ax++) begin : g_axis
      logic signed [31:0] prod;
      logic [POS_W-1:0] pos, anisoOff, half, kernOff;
      logic [IDX_W-1:0] idx;
      logic [FR_W-1:0] fr;
      // the homogeneous component scales before any addressing
      assign prod = $signed(coordIn[ax]) * $signed(coordHomogeneousRecip);
      assign pos = POS_W'(prod >>> FRAC_W) << szIn[ax];
      if (ax < 2) begin : g_plane
        assign anisoOff = POS_W'($signed(POS_W'(ways - 5'h01) * stepIn[ax]) >>> 1);
      end else begin : g_depth
        assign anisoOff = '0;
      end
      assign half = (ax == 0) ? POS_W'(kernelWidth) : POS_W'(kernelHeight);
      assign kernOff = half << (FRAC_W - 1);
      always_comb begin
        case (effFilt)
          FILTER_INTERPOLATED: startPos[ax] = pos - HALF_TEXEL;
          FILTER_ELONGATED_FOOTPRINT: startPos[ax] = pos - anisoOff - HALF_TEXEL;
          FILTER_ONE_BIT_KERNEL: startPos[ax] = pos - kernOff;
          default: startPos[ax] = pos;
        endcase
      end
      assign idx = s_r.cur[ax][FRAC_W +: IDX_W] + IDX_W'(tBit[ax]);
      assign fr = s_r.cur[ax][FRAC_W-1 -: FR_W];
      // nearer texel gets the larger share of the interpolation
      assign wAx[ax] = (2'(ax) >= s_r.nDim) ? WT_ONE :
                       (tBit[ax] ? {1'b0, fr} : WT_ONE - {1'b0, fr});
      tfsa_axis_addr u_addr (
        .idx(idx),
        .sizeLog2(s_r.sz[ax]),
        .mode(tfsa_addr_e'(s_r.mode[ax])),
        .addrIdx(aIdx[ax]),
        .crossLo(crossLo[ax]),
        .crossHi(crossHi[ax])
      );
    end
  endgenerate

  // sample weight and face
  logic [17:0] wUV, wUVR;
  logic [WT_W-1:0] wTex;
  logic [2:0] faceNow;
  logic [4:0] faceSel;
  logic tLast, subLast;
  assign wUV = 18'(wAx[0]) * 18'(wAx[1]);
  assign wUVR = 18'(wUV[16:8]) * 18'(wAx[2]);
  assign wTex = wUVR[16:8];
  assign faceSel = {2'h0, s_r.face} << 2;
  always_comb begin
    faceNow = s_r.face;
    if (s_r.surf == SURF_CUBE) begin
      if (crossLo[0]) faceNow = CUBE_NEXT[faceSel];
      else if (crossHi[0]) faceNow = CUBE_NEXT[faceSel + 5'h01];
      else if (crossLo[1]) faceNow = CUBE_NEXT[faceSel + 5'h02];
      else if (crossHi[1]) faceNow = CUBE_NEXT[faceSel + 5'h03];
    end
  end
  assign tLast = (4'(s_r.t) + 4'h1) == (4'h1 << s_r.nDim);
  assign subLast = (s_r.filt != FILTER_ELONGATED_FOOTPRINT) || (s_r.k == s_r.ways - 5'h01);

  logic [INT_W-1:0] monoI;
  tfsa_mono_kernel u_mono (
    .texels(blkTexels),
    .kernW(s_r.nu),
    .kernH(s_r.nv),
    .fracU(s_r.cur[0][FRAC_W-1 -: FR_W]),
    .fracV(s_r.cur[1][FRAC_W-1 -: FR_W]),
    .intensity(monoI)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.resValid = 1'b0;
    s_nxt.bad = 1'b0;
    if (s_r.smpValid && smpReady) s_nxt.smpValid = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (reqValid) begin
          s_nxt.st = ST_EMIT;
          s_nxt.filt = effFilt;
          s_nxt.surf = surfType;
          s_nxt.face = cubeFace;
          s_nxt.mode = {addrModeR, addrModeV, addrModeU};
          s_nxt.sz = szIn;
          s_nxt.cur = startPos;
          s_nxt.step = stepIn;
          s_nxt.k = '0;
          s_nxt.t = '0;
          s_nxt.ways = ways;
          s_nxt.nDim = reqDim;
          s_nxt.ratio = (effFilt == FILTER_ELONGATED_FOOTPRINT) ? ratioCap : RATIO_ONE;
          s_nxt.endW = endW;
          s_nxt.nu = kernelWidth;
          s_nxt.nv = kernelHeight;
          s_nxt.detAxis = (effFilt == FILTER_ELONGATED_FOOTPRINT) ? minorLen : majorLen;
          s_nxt.bad = fallback;
        end
      end
      ST_EMIT: begin
        if (!s_r.smpValid || smpReady) begin
          s_nxt.smpValid = 1'b1;
          s_nxt.smpIdx = aIdx;
          s_nxt.smpFace = faceNow;
          s_nxt.smpTexW = wTex;
          s_nxt.smpGrpW = RATIO_ONE;
          if (s_r.filt == FILTER_ELONGATED_FOOTPRINT && (s_r.k == '0 || subLast)) begin
            s_nxt.smpGrpW = s_r.endW;
          end
          s_nxt.smpLast = tLast && subLast;
          if (!tLast) s_nxt.t = s_r.t + 3'h1;
          else begin
            s_nxt.t = '0;
            if (!subLast) begin
              s_nxt.k = s_r.k + 5'h01;
              s_nxt.cur[0] = s_r.cur[0] + s_r.step[0];
              s_nxt.cur[1] = s_r.cur[1] + s_r.step[1];
            end else begin
              s_nxt.st = (s_r.filt == FILTER_ONE_BIT_KERNEL) ? ST_BLOCK : ST_IDLE;
            end
          end
        end
      end
      ST_BLOCK: begin
        if (blkValid) begin
          s_nxt.resValid = 1'b1;
          s_nxt.resI = monoI;
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reqReady = s_r.st == ST_IDLE;
  assign blkReady = s_r.st == ST_BLOCK;
  assign smpValid = s_r.smpValid;
  assign smpU = s_r.smpIdx[0];
  assign smpV = s_r.smpIdx[1];
  assign smpR = s_r.smpIdx[2];
  assign smpFace = s_r.smpFace;
  assign smpTexelWeight = s_r.smpTexW;
  assign smpGroupWeight = s_r.smpGrpW;
  assign smpLast = s_r.smpLast;
  assign footprintRatio = s_r.ratio;
  assign detailAxisLen = s_r.detAxis;
  assign unsupportedCombo = s_r.bad;
  assign resValid = s_r.resValid;
  // one intensity fills every channel
  assign resRed = s_r.resI;
  assign resGreen = s_r.resI;
  assign resBlue = s_r.resI;
  assign resAlpha = s_r.resI;
endmodule
`default_nettype wire

/* tfsa_filter_setup_monitor.sv */
/* port checker of the filter setup block; assumes the shared package and top port names. */
`timescale 1ns/100ps
`default_nettype none
module tfsa_filter_setup_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // request and samples
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic smpValid,
  input wire logic smpReady,
  input wire logic [tfsa_pkg::AIDX_W-1:0] smpU,
  input wire logic smpLast,
  input wire tfsa_pkg::tfsa_addr_e addrModeU,
  input wire logic [tfsa_pkg::SZ_W-1:0] sizeLog2U,
  // setup results
  input wire logic [2:0] maxFootprintRatio,
  input wire logic [tfsa_pkg::RATIO_W-1:0] footprintRatio,
  input wire logic unsupportedCombo,
  // one-bit path
  input wire logic blkValid,
  input wire logic blkReady,
  input wire logic resValid,
  input wire logic [tfsa_pkg::INT_W-1:0] resRed,
  input wire logic [tfsa_pkg::INT_W-1:0] resGreen,
  input wire logic [tfsa_pkg::INT_W-1:0] resBlue,
  input wire logic [tfsa_pkg::INT_W-1:0] resAlpha
);
  import tfsa_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_req_answer: assert property (reqValid && reqReady |-> ##2 smpValid)
    else $error("no sample after request");
  // the last sample may still wait while the block is already idle
  chk_busy_refuse: assert property ((smpValid && !smpLast) || blkReady |-> !reqReady)
    else $error("ready while busy");
  chk_sample_hold: assert property (smpValid && !smpReady |=>
    smpValid && $stable(smpU) && $stable(smpLast)) else $error("sample moved while stalled");
  chk_ratio_cap: assert property (reqValid && reqReady |=> footprintRatio >= RATIO_ONE &&
    footprintRatio <= ({6'h00, $past(maxFootprintRatio)} + 9'h001) << 5)
    else $error("ratio outside one and cap");
  // face crossing also wraps into the map, yet only the other modes are bounded here
  chk_index_range: assert property (smpValid && addrModeU != ADDR_FACE_CROSSING |->
    (smpU >> sizeLog2U) == '0) else $error("index off the map");
  chk_combo_pulse: assert property (unsupportedCombo |=> !unsupportedCombo)
    else $error("fallback flag too long");
  chk_block_answer: assert property (blkValid && blkReady |=> resValid ##1 !resValid)
    else $error("result pulse wrong");
  chk_channel_copy: assert property (resValid |-> resRed == resGreen &&
    resGreen == resBlue && resBlue == resAlpha) else $error("channels differ");
  cover property (footprintRatio > RATIO_ONE);
  cover property (blkValid && blkReady);
  cover property (unsupportedCombo);
endmodule
bind tfsa_filter_setup tfsa_filter_setup_monitor u_mon (.clock, .arst_n, .reqValid, .reqReady,
  .smpValid, .smpReady, .smpU, .smpLast, .addrModeU, .sizeLog2U, .maxFootprintRatio,
  .footprintRatio, .unsupportedCombo, .blkValid, .blkReady, .resValid, .resRed, .resGreen,
  .resBlue, .resAlpha);
`default_nettype wire

/* tfsa_mono_kernel.sv */
/*
  one-bit kernel filter over a fetched 8x8 texel block whose corner is the start texel.
  assumes kernel sizes from 1 to 7 and a block row-major, bit j*8+i for column i, row j.
*/
`timescale 1ns/100ps
`default_nettype none
module tfsa_mono_kernel (
  // block and kernel
  input wire logic [tfsa_pkg::BLK_BITS-1:0] texels,
  input wire logic [tfsa_pkg::KN_W-1:0] kernW,
  input wire logic [tfsa_pkg::KN_W-1:0] kernH,
  input wire logic [tfsa_pkg::FR_W-1:0] fracU,
  input wire logic [tfsa_pkg::FR_W-1:0] fracV,
  // intensity
  output logic [tfsa_pkg::INT_W-1:0] intensity
);
  import tfsa_pkg::*;
  logic [6:0] s00, s10, s01, s11;
  logic [5:0] area;
  logic [WT_W-1:0] wu0, wu1, wv0, wv1;
  logic [27:0] acc;
  logic [35:0] num, den;
  always_comb begin
    s00 = '0;
    s10 = '0;
    s01 = '0;
    s11 = '0;
    for (int j = 0; j < BLK; j++) begin
      for (int i = 0; i < BLK; i++) begin
        if (texels[j*BLK+i]) begin
          if (i < kernW && j < kernH) s00 = s00 + 7'h01;
          if (i >= 1 && i <= kernW && j < kernH) s10 = s10 + 7'h01;
          if (i < kernW && j >= 1 && j <= kernH) s01 = s01 + 7'h01;
          if (i >= 1 && i <= kernW && j >= 1 && j <= kernH) s11 = s11 + 7'h01;
        end
      end
    end
  end
  assign wu1 = {1'b0, fracU};
  assign wv1 = {1'b0, fracV};
  assign wu0 = WT_ONE - wu1;
  assign wv0 = WT_ONE - wv1;
  // operands widened first so the full product survives
  assign acc = 28'(wu0) * 28'(wv0) * 28'(s00) + 28'(wu1) * 28'(wv0) * 28'(s10)
             + 28'(wu0) * 28'(wv1) * 28'(s01) + 28'(wu1) * 28'(wv1) * 28'(s11);
  // a zero size would divide by zero, so it counts as one texel
  assign area = (kernW == '0 || kernH == '0) ? 6'h01 : 6'(kernW) * 6'(kernH);
  // a small divider beats a 49-entry reciprocal table here
  assign num = 36'(acc) * 36'(INT_FULL);
  assign den = 36'(area) << (2 * FR_W);
  assign intensity = INT_W'(num / den);
endmodule
`default_nettype wire

/* tfsa_pkg.sv */
/*
  shared constants and types of the texture filter setup and addressing block.
  assumes fixed-point coordinates with FRAC_W fraction bits and power-of-two map sizes.
*/
`default_nettype none
package tfsa_pkg;
  localparam int COORD_W = 16;
  localparam int FRAC_W = 12;
  localparam int POS_W = 40;
  localparam int IDX_W = 16;
  localparam int AIDX_W = 15;
  localparam int FR_W = 8;
  localparam int WT_W = 9;
  localparam int RATIO_W = 9;
  localparam int RFRAC_W = 4;
  localparam int DL_W = 11;
  localparam int SZ_W = 4;
  localparam int LEN_W = 12;
  localparam int KN_W = 3;
  localparam int BLK = 8;
  localparam int BLK_BITS = 64;
  localparam int INT_W = 8;
  localparam int AXES = 3;
  localparam logic [WT_W-1:0] WT_ONE = 9'h100;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 9'h010;
  localparam logic [POS_W-1:0] HALF_TEXEL = 40'h0000000800;
  localparam logic [INT_W-1:0] INT_FULL = 8'hff;
  localparam logic [4:0] WAYS_STEP = 5'h02;
  typedef enum logic [1:0] {
    FILTER_CLOSEST_TEXEL = 2'h0,
    FILTER_INTERPOLATED = 2'h1,
    FILTER_ELONGATED_FOOTPRINT = 2'h2,
    FILTER_ONE_BIT_KERNEL = 2'h3
  } tfsa_filt_e;
  typedef enum logic [2:0] {
    ADDR_REPEAT = 3'h0,
    ADDR_REFLECT = 3'h1,
    ADDR_EDGE_HOLD = 3'h2,
    ADDR_FACE_CROSSING = 3'h3,
    ADDR_REFLECT_THEN_HOLD = 3'h4
  } tfsa_addr_e;
  typedef enum logic [2:0] {
    SURF_1D = 3'h0,
    SURF_2D = 3'h1,
    SURF_3D = 3'h2,
    SURF_CUBE = 3'h3,
    SURF_BUFFER = 3'h4
  } tfsa_surf_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EMIT = 3'h2,
    ST_BLOCK = 3'h4
  } tfsa_state_e;
  // faces +u -u +v -v +r -r; neighbour per edge: u low, u high, v low, v high
  localparam logic [2:0] CUBE_NEXT [0:23] = '{
    3'h4, 3'h5, 3'h2, 3'h3,  3'h5, 3'h4, 3'h2, 3'h3,
    3'h1, 3'h0, 3'h5, 3'h4,  3'h1, 3'h0, 3'h4, 3'h5,
    3'h1, 3'h0, 3'h2, 3'h3,  3'h0, 3'h1, 3'h2, 3'h3};
endpackage
`default_nettype wire
